//--- rtl/sfcd_pkg.sv
// package: opcodes, decode table and constants of the serial flash decoder
package sfcd_pkg;

  // widths and sizes
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;
  localparam int unsigned PIN_N = 4;
  localparam int unsigned ARR_AW = 20;
  localparam logic [19:0] ARRAY_LAST = 20'hfffff;
  localparam logic [19:0] ARRAY_FIRST = 20'h00000;

  // host-side read clock limits in MHz, kept for reference
  localparam int unsigned LOW_FREQ_READ_CLOCK_LIMIT_MHZ = 50;
  localparam int unsigned STD_READ_CLOCK_LIMIT_MHZ = 85;
  localparam int unsigned HS_READ_CLOCK_LIMIT_MHZ = 100;

  // values after reset, and the byte sent when the fifo is empty
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_BIT = 3'h0;
  localparam logic [23:0] RST_ADDR = 24'h000000;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;

  // bit positions within a byte
  localparam int unsigned BYTE_LAST_BIT = 7;
  localparam int unsigned BYTE_LAST_PAIR = 6;

  // opcodes
  localparam logic [7:0] OP_RD_HS = 8'h1b;
  localparam logic [7:0] OP_RD_STD = 8'h0b;
  localparam logic [7:0] OP_RD_LF = 8'h03;
  localparam logic [7:0] OP_RD_DUAL = 8'h3b;
  localparam logic [7:0] OP_ER_4K = 8'h20;
  localparam logic [7:0] OP_ER_32K = 8'h52;
  localparam logic [7:0] OP_ER_64K = 8'hd8;
  localparam logic [7:0] OP_ER_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ER_CHIP_B = 8'hc7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PROT = 8'h36;
  localparam logic [7:0] OP_UNPROT = 8'h39;
  localparam logic [7:0] OP_RD_PROT = 8'h3c;
  localparam logic [7:0] OP_LOCK = 8'h33;
  localparam logic [7:0] OP_FREEZE = 8'h34;
  localparam logic [7:0] OP_RD_LOCK = 8'h35;
  localparam logic [7:0] OP_OTP_PROG = 8'h9b;
  localparam logic [7:0] OP_OTP_RD = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR1 = 8'h01;
  localparam logic [7:0] OP_STAT_WR2 = 8'h31;
  localparam logic [7:0] OP_RESET = 8'hf0;
  localparam logic [7:0] OP_ID_RD = 8'h9f;
  localparam logic [7:0] OP_PD_ENTER = 8'hb9;
  localparam logic [7:0] OP_PD_RESUME = 8'hab;

  typedef enum logic [2:0] {
    SFCD_K_BAD,
    SFCD_K_NONE,
    SFCD_K_WR,
    SFCD_K_WR2,
    SFCD_K_RD,
    SFCD_K_RD2
  } sfcd_kind_t;

  typedef struct packed {
    sfcd_kind_t kind;
    logic [1:0] addr_n;
    logic [1:0] dummy_n;
    logic one_byte;
  } sfcd_dec_t;

  localparam sfcd_dec_t DEC_RST = '{SFCD_K_BAD, 2'd0, 2'd0, 1'b0};

  function automatic sfcd_dec_t sfcd_decode(input logic [7:0] op);
    sfcd_dec_t d;
    d = '{SFCD_K_BAD, 2'd0, 2'd0, 1'b0};
    case (op)
      OP_RD_HS: d = '{SFCD_K_RD, 2'd3, 2'd2, 1'b0};
      OP_RD_STD: d = '{SFCD_K_RD, 2'd3, 2'd1, 1'b0};
      OP_RD_LF: d = '{SFCD_K_RD, 2'd3, 2'd0, 1'b0};
      OP_RD_DUAL: d = '{SFCD_K_RD2, 2'd3, 2'd1, 1'b0};
      OP_ER_4K, OP_ER_32K, OP_ER_64K: d = '{SFCD_K_NONE, 2'd3, 2'd0, 1'b0};
      OP_ER_CHIP_A, OP_ER_CHIP_B: d = '{SFCD_K_NONE, 2'd0, 2'd0, 1'b0};
      OP_PROG: d = '{SFCD_K_WR, 2'd3, 2'd0, 1'b0};
      OP_PROG_DUAL: d = '{SFCD_K_WR2, 2'd3, 2'd0, 1'b0};
      OP_WR_EN, OP_WR_DIS: d = '{SFCD_K_NONE, 2'd0, 2'd0, 1'b0};
      OP_PROT, OP_UNPROT: d = '{SFCD_K_NONE, 2'd3, 2'd0, 1'b0};
      OP_RD_PROT: d = '{SFCD_K_RD, 2'd3, 2'd0, 1'b0};
      OP_LOCK, OP_FREEZE: d = '{SFCD_K_WR, 2'd3, 2'd0, 1'b1};
      OP_RD_LOCK: d = '{SFCD_K_RD, 2'd3, 2'd0, 1'b0};
      OP_OTP_PROG: d = '{SFCD_K_WR, 2'd3, 2'd0, 1'b0};
      OP_OTP_RD: d = '{SFCD_K_RD, 2'd3, 2'd2, 1'b0};
      OP_STAT_RD: d = '{SFCD_K_RD, 2'd0, 2'd0, 1'b0};
      OP_STAT_WR1, OP_STAT_WR2: d = '{SFCD_K_WR, 2'd0, 2'd0, 1'b1};
      OP_RESET: d = '{SFCD_K_WR, 2'd0, 2'd0, 1'b1};
      OP_ID_RD: d = '{SFCD_K_RD, 2'd0, 2'd0, 1'b0};
      OP_PD_ENTER, OP_PD_RESUME: d = '{SFCD_K_NONE, 2'd0, 2'd0, 1'b0};
      default: d = '{SFCD_K_BAD, 2'd0, 2'd0, 1'b0};
    endcase
    return d;
  endfunction

endpackage

//--- rtl/sfcd_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sfcd_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // meta_r feeds only q_r
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule // sfcd_sync

//--- rtl/sfcd_fifo.sv
// flip-flop fifo with valid/ready on both sides and flush
`timescale 1ns/1ps
module sfcd_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != FULL);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush_i) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_nxt = AW'(rp_r + 1'b1);
      end
      cnt_nxt = (AW + 1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; empty slots are never read out as valid
  always_ff @(posedge clock_i) begin
    if (ce_i && push && !flush_i) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

endmodule // sfcd_fifo

//--- rtl/sfcd_top.sv
// serial flash command decoder with sequential read path
`timescale 1ns/1ps
module sfcd_top (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic so_i,
  output logic so_o,
  output logic so_oe_o,
  output logic shared_input_output_pin_o,
  output logic shared_input_output_pin_oe_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [19:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic exec_o,
  output logic [7:0] cmd_op_o,
  output logic [19:0] cmd_addr_o,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OP,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfcd_st_t;

  logic [sfcd_pkg::PIN_N-1:0] pins_s;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic so_s;
  logic sck_q_r;
  logic rise;
  logic fall;

  sfcd_sync #(
    .W(sfcd_pkg::PIN_N)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .d_i({cs_n_i, sck_i, si_i, so_i}),
    .q_o(pins_s)
  );

  assign cs_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign si_s = pins_s[1];
  assign so_s = pins_s[0];
  // both clock idle levels work: only edges inside the frame matter
  assign rise = sck_s && !sck_q_r;
  assign fall = !sck_s && sck_q_r;

  sfcd_st_t st_r, st_nxt;
  sfcd_pkg::sfcd_dec_t dec_r, dec_nxt, dec_new;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic got_r, got_nxt;
  logic [7:0] op_r, op_nxt;
  logic [19:0] cmd_addr_r, cmd_addr_nxt;
  logic exec_r, exec_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] wrd_r, wrd_nxt;
  logic fetch_r, fetch_nxt;
  logic [19:0] raddr_r, raddr_nxt;
  logic [2:0] ob_r, ob_nxt;
  logic [7:0] osh_r, osh_nxt;
  logic so_r, so_nxt;
  logic shr_r, shr_nxt;
  logic so_oe_r, so_oe_nxt;
  logic shr_oe_r, shr_oe_nxt;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [23:0] addr_full;
  logic [7:0] obyte;
  logic is_rd;
  logic is_rd_new;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic push;

  assign byte1 = {sr_r[6:0], si_s};
  assign byte2 = {sr_r[5:0], so_s, si_s};
  assign addr_full = {addr_r[15:0], byte1};
  assign dec_new = sfcd_pkg::sfcd_decode(byte1);
  assign is_rd = (dec_r.kind == sfcd_pkg::SFCD_K_RD) ||
                 (dec_r.kind == sfcd_pkg::SFCD_K_RD2);
  assign is_rd_new = (dec_new.kind == sfcd_pkg::SFCD_K_RD) ||
                     (dec_new.kind == sfcd_pkg::SFCD_K_RD2);
  assign obyte = fifo_out_valid ? fifo_out_data : sfcd_pkg::UNDERRUN_BYTE;

  // prefetch: array bytes are fetched ahead, stalled by fifo fill level
  assign rd_valid_o = fetch_r && fifo_in_ready;
  assign push = rd_valid_o && rd_ready_i;

  sfcd_fifo #(
    .W(sfcd_pkg::FIFO_W),
    .D(sfcd_pkg::FIFO_D)
  ) u_fifo (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .flush_i(cs_s),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    st_nxt = st_r;
    dec_nxt = dec_r;
    bit_nxt = bit_r;
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    got_nxt = got_r;
    op_nxt = op_r;
    cmd_addr_nxt = cmd_addr_r;
    exec_nxt = 1'b0;
    wr_nxt = 1'b0;
    wrd_nxt = wrd_r;
    fetch_nxt = fetch_r;
    raddr_nxt = raddr_r;
    ob_nxt = ob_r;
    osh_nxt = osh_r;
    so_nxt = so_r;
    shr_nxt = shr_r;
    so_oe_nxt = so_oe_r;
    shr_oe_nxt = shr_oe_r;
    pop = 1'b0;
    if (push) begin
      if (raddr_r == sfcd_pkg::ARRAY_LAST) begin
        raddr_nxt = sfcd_pkg::ARRAY_FIRST;
      end else begin
        raddr_nxt = raddr_r + 20'h00001;
      end
    end
    if (cs_s) begin
      // hand-off only for a complete, byte-aligned non-read frame
      if (st_r == ST_DATA && bit_r == sfcd_pkg::RST_BIT && !is_rd &&
          (dec_r.kind == sfcd_pkg::SFCD_K_NONE || got_r)) begin
        exec_nxt = 1'b1;
      end
      st_nxt = ST_IDLE;
      bit_nxt = sfcd_pkg::RST_BIT;
      cnt_nxt = 2'd0;
      got_nxt = 1'b0;
      fetch_nxt = 1'b0;
      ob_nxt = sfcd_pkg::RST_BIT;
      so_oe_nxt = 1'b0;
      shr_oe_nxt = 1'b0;
    end else if (st_r == ST_IDLE) begin
      st_nxt = ST_OP;
    end else begin
      if (rise) begin
        case (st_r)
          ST_OP: begin
            sr_nxt = byte1;
            bit_nxt = bit_r + 3'd1;
            if (bit_r == 3'(sfcd_pkg::BYTE_LAST_BIT)) begin
              op_nxt = byte1;
              dec_nxt = dec_new;
              cnt_nxt = 2'd0;
              if (dec_new.kind == sfcd_pkg::SFCD_K_BAD) begin
                st_nxt = ST_IGNORE;
              end else if (dec_new.addr_n != 2'd0) begin
                st_nxt = ST_ADDR;
              end else begin
                st_nxt = ST_DATA;
                cmd_addr_nxt = sfcd_pkg::ARRAY_FIRST;
                raddr_nxt = sfcd_pkg::ARRAY_FIRST;
                fetch_nxt = is_rd_new;
              end
            end
          end
          ST_ADDR: begin
            sr_nxt = byte1;
            bit_nxt = bit_r + 3'd1;
            if (bit_r == 3'(sfcd_pkg::BYTE_LAST_BIT)) begin
              addr_nxt = addr_full;
              cnt_nxt = cnt_r + 2'd1;
              if (cnt_r == dec_r.addr_n - 2'd1) begin
                cmd_addr_nxt = addr_full[19:0];
                raddr_nxt = addr_full[19:0];
                fetch_nxt = is_rd;
                cnt_nxt = 2'd0;
                if (dec_r.dummy_n != 2'd0) begin
                  st_nxt = ST_DUMMY;
                end else begin
                  st_nxt = ST_DATA;
                end
              end
            end
          end
          ST_DUMMY: begin
            // dummy bits are counted but their value is never used
            bit_nxt = bit_r + 3'd1;
            if (bit_r == 3'(sfcd_pkg::BYTE_LAST_BIT)) begin
              cnt_nxt = cnt_r + 2'd1;
              if (cnt_r == dec_r.dummy_n - 2'd1) begin
                st_nxt = ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (dec_r.kind == sfcd_pkg::SFCD_K_WR) begin
              sr_nxt = byte1;
              bit_nxt = bit_r + 3'd1;
              if (bit_r == 3'(sfcd_pkg::BYTE_LAST_BIT)) begin
                got_nxt = 1'b1;
                // single-byte commands drop anything past the first byte
                if (!(dec_r.one_byte && got_r)) begin
                  wr_nxt = 1'b1;
                  wrd_nxt = byte1;
                end
              end
            end else if (dec_r.kind == sfcd_pkg::SFCD_K_WR2) begin
              sr_nxt = byte2;
              bit_nxt = bit_r + 3'd2;
              if (bit_r == 3'(sfcd_pkg::BYTE_LAST_PAIR)) begin
                got_nxt = 1'b1;
                wr_nxt = 1'b1;
                wrd_nxt = byte2;
              end
            end
          end
          default: begin
            st_nxt = st_r;
          end
        endcase
      end
      if (fall && st_r == ST_DATA && is_rd) begin
        so_oe_nxt = 1'b1;
        if (dec_r.kind == sfcd_pkg::SFCD_K_RD2) begin
          shr_oe_nxt = 1'b1;
          if (ob_r == sfcd_pkg::RST_BIT) begin
            pop = fifo_out_valid;
            so_nxt = obyte[7];
            shr_nxt = obyte[6];
            osh_nxt = {obyte[5:0], 2'b00};
          end else begin
            so_nxt = osh_r[7];
            shr_nxt = osh_r[6];
            osh_nxt = {osh_r[5:0], 2'b00};
          end
          ob_nxt = ob_r + 3'd2;
        end else begin
          if (ob_r == sfcd_pkg::RST_BIT) begin
            pop = fifo_out_valid;
            so_nxt = obyte[7];
            osh_nxt = {obyte[6:0], 1'b0};
          end else begin
            so_nxt = osh_r[7];
            osh_nxt = {osh_r[6:0], 1'b0};
          end
          ob_nxt = ob_r + 3'd1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_q_r <= 1'b0;
      st_r <= ST_IGNORE; // wait for cs high: idle sck is no false edge
      dec_r <= sfcd_pkg::DEC_RST;
      bit_r <= sfcd_pkg::RST_BIT;
      sr_r <= sfcd_pkg::RST_BYTE;
      cnt_r <= 2'd0;
      addr_r <= sfcd_pkg::RST_ADDR;
      got_r <= 1'b0;
      op_r <= sfcd_pkg::RST_BYTE;
      cmd_addr_r <= sfcd_pkg::ARRAY_FIRST;
      exec_r <= 1'b0;
      wr_r <= 1'b0;
      wrd_r <= sfcd_pkg::RST_BYTE;
      fetch_r <= 1'b0;
      raddr_r <= sfcd_pkg::ARRAY_FIRST;
      ob_r <= sfcd_pkg::RST_BIT;
      osh_r <= sfcd_pkg::RST_BYTE;
      so_r <= 1'b0;
      shr_r <= 1'b0;
      so_oe_r <= 1'b0;
      shr_oe_r <= 1'b0;
    end else if (ce_i) begin
      sck_q_r <= sck_s;
      st_r <= st_nxt;
      dec_r <= dec_nxt;
      bit_r <= bit_nxt;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      got_r <= got_nxt;
      op_r <= op_nxt;
      cmd_addr_r <= cmd_addr_nxt;
      exec_r <= exec_nxt;
      wr_r <= wr_nxt;
      wrd_r <= wrd_nxt;
      fetch_r <= fetch_nxt;
      raddr_r <= raddr_nxt;
      ob_r <= ob_nxt;
      osh_r <= osh_nxt;
      so_r <= so_nxt;
      shr_r <= shr_nxt;
      so_oe_r <= so_oe_nxt;
      shr_oe_r <= shr_oe_nxt;
    end
  end

  assign so_o = so_r;
  assign so_oe_o = so_oe_r;
  assign shared_input_output_pin_o = shr_r;
  assign shared_input_output_pin_oe_o = shr_oe_r;
  assign rd_addr_o = raddr_r;
  assign exec_o = exec_r;
  assign cmd_op_o = op_r;
  assign cmd_addr_o = cmd_addr_r;
  assign wr_valid_o = wr_r;
  assign wr_data_o = wrd_r;

endmodule // sfcd_top

//--- sim/sfcd_checker.sv
// checker: concurrent assertions on the decoder top ports
`timescale 1ns/1ps
module sfcd_checker (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic shared_input_output_pin_oe_o,
  input wire logic rd_valid_o,
  input wire logic rd_ready_i,
  input wire logic [19:0] rd_addr_o,
  input wire logic exec_o,
  input wire logic [7:0] cmd_op_o,
  input wire logic wr_valid_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  // six cycles covers the two sync stages plus the output register
  sequence s_cs_idle;
    cs_n_i [*6];
  endsequence
  sequence s_quiet;
    !so_oe_o && !shared_input_output_pin_oe_o && !rd_valid_o;
  endsequence
  property p_float;
    s_cs_idle |-> s_quiet;
  endproperty
  a_float: assert property (p_float)
    else $error("output or fetch active while cs is high");
  property p_dual;
    shared_input_output_pin_oe_o |-> so_oe_o;
  endproperty
  a_dual: assert property (p_dual)
    else $error("shared pin driven without serial output");
  property p_exec_cs;
    exec_o |-> $past(cs_n_i, 2);
  endproperty
  a_exec_cs: assert property (p_exec_cs)
    else $error("command handed off before cs went high");
  property p_exec_rd;
    exec_o |-> !(cmd_op_o inside {8'h03, 8'h0b, 8'h1b, 8'h3b, 8'h77,
                                  8'h3c, 8'h35, 8'h05, 8'h9f});
  endproperty
  a_exec_rd: assert property (p_exec_rd)
    else $error("array read handed off as a command");
  property p_so_fall;
    so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sck_i, 2);
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("serial output changed away from a falling clock");
  property p_addr_step;
    rd_valid_o && rd_ready_i && !cs_n_i && $past(!cs_n_i)
      |=> rd_addr_o == $past(rd_addr_o) + 20'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("fetch address did not advance by one");
  property p_wr_gap;
    wr_valid_o |=> (!wr_valid_o) [*8];
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("data bytes reported too close together");
  property p_oe_fall;
    $fell(so_oe_o) |-> $past(cs_n_i, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("serial output released while cs low");
endmodule // sfcd_checker

bind sfcd_top sfcd_checker sfcd_checker_inst (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .cs_n_i(cs_n_i),
  .sck_i(sck_i),
  .so_o(so_o),
  .so_oe_o(so_oe_o),
  .shared_input_output_pin_oe_o(shared_input_output_pin_oe_o),
  .rd_valid_o(rd_valid_o),
  .rd_ready_i(rd_ready_i),
  .rd_addr_o(rd_addr_o),
  .exec_o(exec_o),
  .cmd_op_o(cmd_op_o),
  .wr_valid_o(wr_valid_o)
);

//--- sim/sfcd_host.sv
// host bus master model: cs, mode 0 serial clock, data lines
`timescale 1ns/1ps
module sfcd_host (
  input wire logic clock_i,
  input wire logic so_w_i,
  input wire logic shr_w_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic so_o,
  output logic so_en_o
);
  // 25 clocks a serial period: 125 ns, under every read limit
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    so_o = 1'b0;
    so_en_o = 1'b0;
  end
  // data set with the fall, sampled just before the rise
  task automatic bit2(input logic hi, input logic lo, input logic en,
                      output logic [1:0] got);
    si_o = lo;
    so_o = hi;
    so_en_o = en;
    repeat (12) @(negedge clock_i);
    got = {so_w_i, shr_w_i};
    sck_o = 1'b1;
    repeat (13) @(negedge clock_i);
    sck_o = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    logic [1:0] g;
    for (int i = 7; i >= 0; i--) begin
      bit2(1'b0, d[i], 1'b0, g);
      q[i] = g[1];
    end
  endtask
  task automatic dbyte(input logic [7:0] d, input logic en,
                       output logic [7:0] q);
    logic [1:0] g;
    for (int i = 3; i >= 0; i--) begin
      bit2(d[2*i+1], d[2*i], en, g);
      q[2*i+1 -: 2] = g;
    end
  endtask
  task automatic start();
    cs_n_o = 1'b0;
    repeat (12) @(negedge clock_i);
  endtask
  // si shows the inverse of its last level and so is released
  task automatic stop();
    repeat (12) @(negedge clock_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    so_en_o = 1'b0;
    repeat (20) @(negedge clock_i);
  endtask
endmodule // sfcd_host

//--- sim/test_sfcd_top.sv
// testbench: host frames against the decoder with an array model
`timescale 1ns/1ps
module test_sfcd_top;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic rd_ready_i = 1'b0;
  logic pat = 1'b0;
  logic [31:0] rng = 32'h1f;
  logic cs_n_i, sck_i, si_i, so_i, h_si, h_so, h_so_en;
  logic so_o, so_oe_o, shr_o, shr_oe, rd_valid_o, exec_o, wr_valid_o;
  logic [19:0] rd_addr_o, cmd_addr_o;
  logic [7:0] rd_data_i, cmd_op_o, wr_data_o;
  logic [31:0] wrq [$];
  logic [31:0] exq [$];
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] rop [8] = '{8'h03, 8'h0b, 8'h1b, 8'h77, 8'h3c, 8'h35, 8'h05,
                          8'h9f};
  int rna [8] = '{3, 3, 3, 3, 3, 3, 0, 0};
  int rdm [8] = '{0, 1, 2, 2, 0, 0, 0, 0};
  // op, address bytes, then nw*4 + extra*2 + dual
  logic [15:0] wt [19] = '{16'h2030, 16'h5230, 16'hd830, 16'h6000,
    16'hc700, 16'h3630, 16'h3930, 16'hb900, 16'hab00, 16'h0600, 16'h0400,
    16'h0238, 16'ha239, 16'h9b34, 16'h3336, 16'h3436, 16'h0106, 16'h3106,
    16'hf006};

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] mem(input logic [19:0] a);
    return a[7:0] ^ {a[19:16], a[11:8]} ^ 8'h5c;
  endfunction
  // array answers in the same cycle; random ready stalls hold back the fifo fill
  assign rd_data_i = mem(rd_addr_o);
  assign si_i = shr_oe ? shr_o : h_si;
  assign so_i = so_oe_o ? so_o : (h_so_en ? h_so : pat);
  always @(negedge clock_i) begin
    rng <= xs(rng);
    pat <= ~pat;
    rd_ready_i <= rng[0] | rng[1];
  end

  sfcd_top sfcd_top_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .so_i(so_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .shared_input_output_pin_o(shr_o),
    .shared_input_output_pin_oe_o(shr_oe), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .exec_o(exec_o), .cmd_op_o(cmd_op_o), .cmd_addr_o(cmd_addr_o),
    .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o));
  sfcd_host sfcd_host_inst (.clock_i(clock_i), .so_w_i(so_i),
    .shr_w_i(si_i), .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(h_si),
    .so_o(h_so), .so_en_o(h_so_en));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // pulses are looked at mid-cycle, away from the edge that launches them
  always @(negedge clock_i) begin
    if (wr_valid_o === 1'b1)
      check({24'h0, wr_data_o}, wrq.size() > 0 ? wrq.pop_front() : '1);
    if (exec_o === 1'b1)
      check({4'h0, cmd_op_o, cmd_addr_o}, exq.size() > 0 ? exq.pop_front()
            : '1);
  end

  task automatic rd_cmd(input logic [7:0] op, input int na, input int nd,
                        input logic [23:0] a, input int n, input logic dual);
    logic [7:0] q;
    logic [1:0] g;
    logic [19:0] p;
    sfcd_host_inst.start();
    sfcd_host_inst.xbyte(op, q);
    for (int i = na - 1; i >= 0; i--) sfcd_host_inst.xbyte(a[8*i +: 8], q);
    for (int i = 0; i < nd; i++) sfcd_host_inst.xbyte(rng[7:0], q);
    check({31'h0, so_oe_o}, 32'h0);
    p = (na == 0) ? 20'h0 : a[19:0];
    for (int i = 0; i < n; i++) begin
      if (dual) sfcd_host_inst.dbyte(8'h00, 1'b0, q);
      else sfcd_host_inst.xbyte(rng[7:0], q);
      check({24'h0, q}, {24'h0, mem(p)});
      p = p + 20'h1;
    end
    // stop three bits into a byte
    repeat (3) sfcd_host_inst.bit2(1'b0, 1'b0, 1'b0, g);
    sfcd_host_inst.stop();
    check({30'h0, so_oe_o, shr_oe}, 32'h0);
  endtask
  // good low: no hand-off and no byte may come out
  task automatic wr_cmd(input logic [7:0] op, input int na, input int nw,
    input int nx, input logic dual, input logic [23:0] a, input logic good);
    logic [7:0] q;
    logic [7:0] d;
    sfcd_host_inst.start();
    sfcd_host_inst.xbyte(op, q);
    for (int i = na - 1; i >= 0; i--) sfcd_host_inst.xbyte(a[8*i +: 8], q);
    for (int i = 0; i < nw + nx; i++) begin
      d = rng[7:0];
      if (good && i < nw) wrq.push_back({24'h0, d});
      if (dual) sfcd_host_inst.dbyte(d, 1'b1, q);
      else sfcd_host_inst.xbyte(d, q);
    end
    if (good) exq.push_back({4'h0, op, na > 0 ? a[19:0] : 20'h0});
    sfcd_host_inst.stop();
  endtask

  initial begin
    repeat (90000) @(posedge clock_i);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (10) @(negedge clock_i);
    for (int k = 0; k < 8; k++)
      rd_cmd(rop[k], rna[k], rdm[k], rng[23:0], 3, 1'b0);
    rd_cmd(8'h0b, 3, 1, 24'hafffff, 3, 1'b0);
    rd_cmd(8'h3b, 3, 1, rng[23:0], 2, 1'b1);
    $display("test reads done");
    for (int k = 0; k < 19; k++)
      wr_cmd(wt[k][15:8], wt[k][7:4], wt[k][3:2], wt[k][1], wt[k][0],
             rng[23:0], 1'b1);
    wr_cmd(8'h5a, 3, 0, 2, 1'b0, rng[23:0], 1'b0);
    wr_cmd(8'h20, 2, 0, 0, 1'b0, rng[23:0], 1'b0);
    repeat (30) @(negedge clock_i);
    check(wrq.size(), 32'h0);
    check(exq.size(), 32'h0);
    $display("test commands done");
    close_out();
  end
endmodule // test_sfcd_top
